// ===== shared/lemc_pkg.sv
// package of register map, field layout and reset values for the misc control bank
// Notes on behaviour
// - clock pin input at 0, oscillator out at 1
// - pin function 00 makes pin engine trigger
// - pin function resets 01, drives engine interrupt
// - pin function 10 or 11 is host output
// - host output level bit drives pin, resets 0
// - shared 8-bit variable register, reset zero
// - engines read shared variable for branching
// - writing FFh to reset register resets device
// - software reset restores every register default
// - reset register reads back zero always
// - three engine local variables, host accessible too
// - group dimmers are 8-bit scaling registers
// - engine one may write group dimmer one
// - engine two may write group dimmer two
// - control bits 7..4 reserved, read/write, zero
package lemc_pkg;
    localparam logic [7:0] LEMC_ADDR_IO_CTRL  = 8'h3D;
    localparam logic [7:0] LEMC_ADDR_SHARED   = 8'h3E;
    localparam logic [7:0] LEMC_ADDR_SW_RESET = 8'h3F;
    localparam logic [7:0] LEMC_ADDR_ENG1_VAR = 8'h42;
    localparam logic [7:0] LEMC_ADDR_ENG2_VAR = 8'h43;
    localparam logic [7:0] LEMC_ADDR_ENG3_VAR = 8'h44;
    localparam logic [7:0] LEMC_ADDR_DIM1     = 8'h46;
    localparam logic [7:0] LEMC_ADDR_DIM2     = 8'h47;
    localparam logic [7:0] LEMC_RST_IO_CTRL   = 8'h02;
    localparam logic [7:0] LEMC_RST_ZERO      = 8'h00;
    localparam logic [7:0] LEMC_SW_RESET_KEY  = 8'hFF;
    localparam int         LEMC_BIT_CLK_OUT   = 3;
    localparam int         LEMC_BIT_FUNC_HI   = 2;
    localparam int         LEMC_BIT_FUNC_LO   = 1;
    localparam int         LEMC_BIT_GPO       = 0;
    localparam int         LEMC_NUM_ENG       = 3;
    typedef enum logic [1:0] {
        LEMC_PIN_TRIG = 2'h0,
        LEMC_PIN_INT  = 2'h1,
        LEMC_PIN_GPO0 = 2'h2,
        LEMC_PIN_GPO1 = 2'h3
    } lemc_pin_func_t;
endpackage : lemc_pkg

// ===== shared/lemc_pin_if.sv
// interface carrying the pin control fields from the register bank to the pin mux
`timescale 1ns/1ps
interface lemc_pin_if;
    logic [1:0] pin_func;
    logic       gpo_level;
    logic       clk_out_en;
    modport regs (output pin_func, output gpo_level, output clk_out_en);
    modport pins (input pin_func, input gpo_level, input clk_out_en);
endinterface : lemc_pin_if

// ===== design/lemc_pin_mux.sv
// multipurpose pin and clock pin direction logic
`timescale 1ns/1ps
module lemc_pin_mux
    import lemc_pkg::*;
(
    lemc_pin_if.pins  ctl,
    input  wire logic engine_irq,
    input  wire logic mp_pin_i,
    input  wire logic osc_clk,
    output logic      mp_pin_o,
    output logic      mp_pin_oe,
    output logic      engine_trigger,
    output logic      clk_pin_o,
    output logic      clk_pin_oe
);
    always_comb begin
        mp_pin_o       = 1'b0;
        mp_pin_oe      = 1'b0;
        engine_trigger = 1'b0;
        unique case (ctl.pin_func)
            LEMC_PIN_TRIG: engine_trigger = mp_pin_i;
            LEMC_PIN_INT: begin
                // open-drain style: pull low while engines flag an event
                mp_pin_o  = 1'b0;
                mp_pin_oe = engine_irq;
            end
            LEMC_PIN_GPO0, LEMC_PIN_GPO1: begin
                mp_pin_o  = ctl.gpo_level;
                mp_pin_oe = 1'b1;
            end
        endcase
    end
    assign clk_pin_oe = ctl.clk_out_en;
    assign clk_pin_o  = ctl.clk_out_en & osc_clk;
endmodule : lemc_pin_mux

// ===== design/lemc_regs.sv
// misc control register bank: pin control, engine variables, group dimmers, soft reset
`timescale 1ns/1ps
module lemc_regs
    import lemc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic [2:0] eng_var_wr,
    input  wire logic [7:0] eng_var_wdata [3],
    input  wire logic       eng1_dim_wr,
    input  wire logic [7:0] eng1_dim_wdata,
    input  wire logic       eng2_dim_wr,
    input  wire logic [7:0] eng2_dim_wdata,
    input  wire logic       engine_irq,
    input  wire logic       mp_pin_i,
    input  wire logic       osc_clk,
    output logic            mp_pin_o,
    output logic            mp_pin_oe,
    output logic            engine_trigger,
    output logic            clk_pin_o,
    output logic            clk_pin_oe,
    output logic [7:0]      shared_var,
    output logic [7:0]      eng_local_var [3],
    output logic [7:0]      group_dimmer_one,
    output logic [7:0]      group_dimmer_two,
    output logic            soft_reset_pulse
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] io_ctrl_q;
    logic [7:0] shared_q;
    logic [7:0] eng_var_q [3];
    logic [7:0] dim1_q;
    logic [7:0] dim2_q;
    logic       sw_rst_q;
    logic       clr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    // soft reset acts one cycle after the key write; the write cycle itself is dropped
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sw_rst_q <= 1'b0;
        end else begin
            sw_rst_q <= reg_wr && hit(reg_addr, LEMC_ADDR_SW_RESET)
                        && reg_wdata == LEMC_SW_RESET_KEY;
        end
    end
    assign clr              = !rstn || sw_rst_q;
    assign soft_reset_pulse = sw_rst_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            io_ctrl_q <= LEMC_RST_IO_CTRL;
        end else if (reg_wr && hit(reg_addr, LEMC_ADDR_IO_CTRL)) begin
            io_ctrl_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            shared_q <= LEMC_RST_ZERO;
        end else if (reg_wr && hit(reg_addr, LEMC_ADDR_SHARED)) begin
            shared_q <= reg_wdata;
        end
    end

    // engine write wins over a host write in the same cycle: program state is live
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < LEMC_NUM_ENG; i++) begin
            if (clr) begin
                eng_var_q[i] <= LEMC_RST_ZERO;
            end else if (eng_var_wr[i]) begin
                eng_var_q[i] <= eng_var_wdata[i];
            end else if (reg_wr && hit(reg_addr, LEMC_ADDR_ENG1_VAR + 8'(i))) begin
                eng_var_q[i] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            dim1_q <= LEMC_RST_ZERO;
        end else if (eng1_dim_wr) begin
            dim1_q <= eng1_dim_wdata;
        end else if (reg_wr && hit(reg_addr, LEMC_ADDR_DIM1)) begin
            dim1_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            dim2_q <= LEMC_RST_ZERO;
        end else if (eng2_dim_wr) begin
            dim2_q <= eng2_dim_wdata;
        end else if (reg_wr && hit(reg_addr, LEMC_ADDR_DIM2)) begin
            dim2_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data registered; unmapped addresses and the reset register read zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= LEMC_RST_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                LEMC_ADDR_IO_CTRL:  reg_rdata <= io_ctrl_q;
                LEMC_ADDR_SHARED:   reg_rdata <= shared_q;
                LEMC_ADDR_SW_RESET: reg_rdata <= LEMC_RST_ZERO;
                LEMC_ADDR_ENG1_VAR: reg_rdata <= eng_var_q[0];
                LEMC_ADDR_ENG2_VAR: reg_rdata <= eng_var_q[1];
                LEMC_ADDR_ENG3_VAR: reg_rdata <= eng_var_q[2];
                LEMC_ADDR_DIM1:     reg_rdata <= dim1_q;
                LEMC_ADDR_DIM2:     reg_rdata <= dim2_q;
                default:            reg_rdata <= LEMC_RST_ZERO;
            endcase
        end
    end

    assign shared_var       = shared_q;
    assign eng_local_var    = eng_var_q;
    assign group_dimmer_one = dim1_q;
    assign group_dimmer_two = dim2_q;

    ////////////////////////////////////////////////////////////////////////////
    lemc_pin_if pin_bus ();
    assign pin_bus.pin_func   = io_ctrl_q[LEMC_BIT_FUNC_HI:LEMC_BIT_FUNC_LO];
    assign pin_bus.gpo_level  = io_ctrl_q[LEMC_BIT_GPO];
    assign pin_bus.clk_out_en = io_ctrl_q[LEMC_BIT_CLK_OUT];

    lemc_pin_mux u_pin_mux (
        .ctl            (pin_bus.pins),
        .engine_irq     (engine_irq),
        .mp_pin_i       (mp_pin_i),
        .osc_clk        (osc_clk),
        .mp_pin_o       (mp_pin_o),
        .mp_pin_oe      (mp_pin_oe),
        .engine_trigger (engine_trigger),
        .clk_pin_o      (clk_pin_o),
        .clk_pin_oe     (clk_pin_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    a_io_reset_value: assert property (@(posedge clk_sys) !rstn |=> io_ctrl_q == 8'h02 && mp_pin_oe == engine_irq)
        else $error("io control not at default after reset");
    a_soft_reset_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == 8'h3F && reg_wdata == 8'hFF ##1 !eng1_dim_wr |=> dim1_q == 8'h00 && shared_q == 8'h00)
        else $error("soft reset left state behind");
    a_soft_reset_io: assert property (@(posedge clk_sys) disable iff (!rstn)
        sw_rst_q |=> io_ctrl_q == 8'h02)
        else $error("soft reset left io control");
    a_other_key_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == 8'h3F && reg_wdata != 8'hFF && !sw_rst_q |=> !sw_rst_q && $stable(shared_q))
        else $error("non-key write changed state");
    a_reset_reg_reads_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == 8'h3F |=> reg_rdata == 8'h00)
        else $error("reset register read nonzero");
    a_gpo_drives_pin: assert property (@(posedge clk_sys) disable iff (!rstn)
        io_ctrl_q[2] |-> mp_pin_oe && mp_pin_o == io_ctrl_q[0])
        else $error("host output level not on pin");
    a_clk_pin_dir: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_pin_oe == io_ctrl_q[3])
        else $error("clock pin direction wrong");
    a_trigger_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
        io_ctrl_q[2:1] == 2'h0 |-> !mp_pin_oe && engine_trigger == mp_pin_i)
        else $error("trigger mode pin misused");
    a_eng1_dimmer: assert property (@(posedge clk_sys) disable iff (!rstn)
        eng1_dim_wr && !(reg_wr && reg_addr == 8'h3F && reg_wdata == 8'hFF) && !sw_rst_q
        |=> group_dimmer_one == $past(eng1_dim_wdata))
        else $error("engine one dimmer write lost");
    a_eng2_dimmer: assert property (@(posedge clk_sys) disable iff (!rstn)
        eng2_dim_wr && !(reg_wr && reg_addr == 8'h3F && reg_wdata == 8'hFF) && !sw_rst_q
        |=> group_dimmer_two == $past(eng2_dim_wdata))
        else $error("engine two dimmer write lost");
    a_reserved_rw: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == 8'h3D && !sw_rst_q ##1 reg_rd && reg_addr == 8'h3D && !reg_wr && !sw_rst_q
        |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 2))
        else $error("reserved bits not stored");
    c_soft_reset: cover property (@(posedge clk_sys) sw_rst_q);
    c_gpo_mode: cover property (@(posedge clk_sys) io_ctrl_q[2:1] == 2'h2 && mp_pin_o);
    c_trigger_mode: cover property (@(posedge clk_sys) io_ctrl_q[2:1] == 2'h0 && engine_trigger);
    c_clk_out: cover property (@(posedge clk_sys) clk_pin_oe);
endmodule : lemc_regs

// ===== verif/lemc_pin_model.sv
// far-side model of the multipurpose pin wire with its pull-up
`timescale 1ns/1ps
module lemc_pin_model (
    input  wire logic mp_pin_o,
    input  wire logic mp_pin_oe,
    input  wire logic ext_oe,
    input  wire logic ext_level,
    output logic      pin_level
);
    // device drive wins, then the external trigger source, else the pull-up
    assign pin_level = mp_pin_oe ? mp_pin_o : (ext_oe ? ext_level : 1'b1);
endmodule : lemc_pin_model

// ===== verif/led_engine_misc_control_regs_tb.sv
// self-checking bench for the misc control register bank
`timescale 1ns/1ps
module led_engine_misc_control_regs_tb
    import lemc_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       rstn, reg_wr, reg_rd, engine_irq, osc_clk, mp_pin_i, ext_oe, ext_level;
    logic       eng1_dim_wr, eng2_dim_wr, mp_pin_o, mp_pin_oe, engine_trigger, clk_pin_o, clk_pin_oe;
    logic       soft_reset_pulse;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, eng1_dim_wdata, eng2_dim_wdata, shared_var;
    logic [7:0] group_dimmer_one, group_dimmer_two, rd_v;
    logic [2:0] eng_var_wr;
    logic [7:0] eng_var_wdata [3];
    logic [7:0] eng_local_var [3];
    int         miscompares = 0;
    int         cmp_count = 0;
    logic [7:0] addr_tab [8] = '{8'h3D, 8'h3E, 8'h3F, 8'h42, 8'h43, 8'h44, 8'h46, 8'h47};
    logic [7:0] rst_tab [8] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // {io value, external level, expected {oe, driven level, trigger, clk oe, clk out}}
    logic [13:0] pin_tab [7] = '{{8'h00, 1'b1, 5'h04}, {8'h00, 1'b0, 5'h00}, {8'h02, 1'b1, 5'h10},
                                 {8'h05, 1'b1, 5'h18}, {8'h06, 1'b1, 5'h10}, {8'h07, 1'b0, 5'h18},
                                 {8'h08, 1'b1, 5'h07}};

    always #10 clk_sys = ~clk_sys;

    lemc_regs dut (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .eng_var_wr(eng_var_wr), .eng_var_wdata(eng_var_wdata),
        .eng1_dim_wr(eng1_dim_wr), .eng1_dim_wdata(eng1_dim_wdata), .eng2_dim_wr(eng2_dim_wr),
        .eng2_dim_wdata(eng2_dim_wdata), .engine_irq(engine_irq), .mp_pin_i(mp_pin_i), .osc_clk(osc_clk),
        .mp_pin_o(mp_pin_o), .mp_pin_oe(mp_pin_oe), .engine_trigger(engine_trigger), .clk_pin_o(clk_pin_o),
        .clk_pin_oe(clk_pin_oe), .shared_var(shared_var), .eng_local_var(eng_local_var),
        .group_dimmer_one(group_dimmer_one), .group_dimmer_two(group_dimmer_two),
        .soft_reset_pulse(soft_reset_pulse));

    lemc_pin_model pm (.mp_pin_o(mp_pin_o), .mp_pin_oe(mp_pin_oe), .ext_oe(ext_oe), .ext_level(ext_level),
        .pin_level(mp_pin_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
    endtask : wr

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // read data is registered, so it is taken one cycle after the strobe
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        chk(n, e, reg_rdata);
    endtask : rchk

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #50us;
        miscompares++;
        give_verdict();
    end

    initial begin
        {rstn, reg_wr, reg_rd, engine_irq, osc_clk, ext_oe, ext_level, eng1_dim_wr, eng2_dim_wr} = '0;
        {reg_addr, reg_wdata, eng1_dim_wdata, eng2_dim_wdata, eng_var_wr} = '0;
        eng_var_wdata = '{default: 8'h00};
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) rchk("reset value", addr_tab[i], rst_tab[i]);
        rchk("unmapped read", 8'h40, 8'h00);
        chk("int pin idle", 8'h00, {7'h00, mp_pin_oe});
        $display("test reset values finished");
        for (int p = 0; p < 2; p++) begin
            for (int i = 1; i < 8; i++) wr(addr_tab[i], p ? 8'h5A : 8'hA5);
            wr(LEMC_ADDR_IO_CTRL, p ? 8'h50 : 8'hA0);
            chk("shared out", p ? 8'h5A : 8'hA5, shared_var);
            chk("dimmer two out", p ? 8'h5A : 8'hA5, group_dimmer_two);
            rchk("io reserved", LEMC_ADDR_IO_CTRL, p ? 8'h50 : 8'hA0);
            for (int i = 1; i < 8; i++) rchk("rw readback", addr_tab[i], (i == 2) ? 8'h00 : (p ? 8'h5A : 8'hA5));
        end
        $display("test read write finished");
        for (int i = 0; i < 7; i++) begin
            wr(LEMC_ADDR_IO_CTRL, pin_tab[i][13:6]);
            engine_irq = 1'b1;
            osc_clk    = 1'b1;
            ext_oe     = (pin_tab[i][8:7] == 2'b00);
            ext_level  = pin_tab[i][5];
            #1;
            chk("pin mode", {3'h0, pin_tab[i][4:0]},
                {3'h0, mp_pin_oe, mp_pin_oe & mp_pin_o, engine_trigger, clk_pin_oe, clk_pin_o});
        end
        ext_oe = 1'b0;
        osc_clk = 1'b0;
        #1;
        chk("clock pin follows osc", 8'h01, {7'h00, clk_pin_oe & ~clk_pin_o});
        $display("test pin modes finished");
        @(negedge clk_sys);
        eng_var_wr     = 3'b111;
        eng_var_wdata  = '{8'h11, 8'h22, 8'h33};
        {eng1_dim_wr, eng2_dim_wr} = 2'b11;
        eng1_dim_wdata = 8'h44;
        eng2_dim_wdata = 8'h55;
        reg_wr         = 1'b1;
        reg_addr       = LEMC_ADDR_DIM1;
        reg_wdata      = 8'h99;
        @(negedge clk_sys);
        {reg_wr, eng1_dim_wr, eng2_dim_wr, eng_var_wr} = '0;
        for (int i = 0; i < 3; i++) chk("engine var out", 8'(8'h11 * (i + 1)), eng_local_var[i]);
        for (int i = 0; i < 3; i++) rchk("engine var", addr_tab[i + 3], 8'(8'h11 * (i + 1)));
        rchk("dimmer one", LEMC_ADDR_DIM1, 8'h44);
        rchk("dimmer two", LEMC_ADDR_DIM2, 8'h55);
        $display("test engine writes finished");
        wr(LEMC_ADDR_SW_RESET, 8'hFE);
        rchk("no reset on other key", LEMC_ADDR_DIM1, 8'h44);
        wr(LEMC_ADDR_SW_RESET, 8'hFF);
        chk("reset pulse", 8'h01, {7'h00, soft_reset_pulse});
        @(negedge clk_sys);
        chk("dimmer one cleared", 8'h00, group_dimmer_one);
        for (int i = 0; i < 8; i++) rchk("after soft reset", addr_tab[i], rst_tab[i]);
        $display("test soft reset finished");
        give_verdict();
    end
endmodule : led_engine_misc_control_regs_tb
